// ==== pkg/optcfg_pkg.sv ====
// constants for the system option latch block
package optcfg_pkg;
  // register offset (byte address of the option latches)
  localparam logic [15:0] OPT_ADDR = 16'h001F;
  // field positions
  localparam int unsigned B_SLOW  = 7;
  localparam int unsigned B_LVSTP = 6;
  localparam int unsigned B_LVRST = 5;
  localparam int unsigned B_LVPWR = 4;
  localparam int unsigned B_WDRS  = 3;
  localparam int unsigned B_SHORT_STOP_RECOVERY = 2;
  localparam int unsigned B_STOP  = 1;
  localparam int unsigned B_WDDIS = 0;
  // reset value: detector reset enable and power set
  localparam logic [7:0] OPT_RESET = 8'h30;
  // timing counts in oscillator clock cycles
  localparam logic [12:0] STOP_SHORT_CYC = 13'h0020;
  localparam logic [12:0] STOP_LONG_CYC  = 13'h1000;
  localparam logic [18:0] WD_SHORT_CYC   = 19'h01FF0;
  localparam logic [18:0] WD_LONG_CYC    = 19'h3FFF0;
  localparam logic [12:0] CNT_ONE        = 13'h0001;
  localparam logic [12:0] CNT_ZERO       = 13'h0000;

  typedef enum logic [2:0] {
    S_RUN  = 3'h1,
    S_STOP = 3'h2,
    S_WAIT = 3'h4
  } optcfg_state_t;
endpackage

// ==== rtl/optcfg_top.sv ====
// write-once system option latches with stop recovery timing
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps
// Summary of operation
// - slow select configures clock generator crystal range
// - slow select sets clock monitor expected range
// - detector runs in stop if power and enable
// - reset enable gates detector reset request
// - power bit turns detector on or off
// - rate select picks watchdog timeout length
// - short recovery bit gives 32 or 4096 cycles
// - external reset exit always uses long recovery
// - power-on reset waits 4096 oscillator cycles
// - stop enable clear makes STOP illegal opcode
// - watchdog disable bit turns watchdog off
// - monitor high voltage holds watchdog disabled
// - voltage removed: disable bit governs watchdog
// - only first write after reset is accepted
// - register sits at fixed address, latches
// - reset sets detector reset and power bits
module optcfg_top (
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rstn,
  // register port
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  // oscillator clock tick and system events
  input  wire logic        i_osc_tick,
  input  wire logic        i_stop_req,
  input  wire logic        i_wake,
  input  wire logic        i_ext_reset,
  input  wire logic        i_por,
  // low-voltage detector
  input  wire logic        i_lvd_trip,
  output logic             o_lvd_power,
  output logic             o_lvd_stop_run,
  output logic             o_lvd_reset_req,
  // clock generator
  output logic             o_slow_crystal,
  output logic             o_mon_expect_low,
  // cpu decoder and stop control
  output logic             o_stop_legal,
  output logic             o_stop_illegal,
  output logic             o_in_stop,
  output logic             o_recovering,
  // watchdog
  input  wire logic        i_monitor_mode,
  input  wire logic        i_hv_irq,
  input  wire logic        i_hv_rst,
  output logic             o_wd_enable,
  output logic             o_wd_rate_short,
  output logic      [18:0] o_wd_timeout
);

  typedef struct packed {
    logic [7:0]                  opt;
    logic                        used;
    logic [7:0]                  rdata;
    optcfg_pkg::optcfg_state_t   st;
    logic [12:0]                 cnt;
  } optcfg_regs_t;

  optcfg_regs_t r_q;
  optcfg_regs_t r_d;

  logic hit;
  logic long_rec;

  assign hit = (i_addr == optcfg_pkg::OPT_ADDR);

  always_comb begin
    r_d = r_q;
    long_rec = 1'b0;
    // one write per reset; later writes ignored
    if (i_wr && hit && !r_q.used) begin
      r_d.opt  = i_wdata;
      r_d.used = 1'b1;
    end
    // read data valid the cycle after the strobe
    if (i_rd && hit) begin
      r_d.rdata = r_q.opt;
    end else begin
      r_d.rdata = 8'h00;
    end
    case (r_q.st)
      optcfg_pkg::S_RUN: begin
        if (i_stop_req && r_q.opt[optcfg_pkg::B_STOP]) begin
          r_d.st = optcfg_pkg::S_STOP;
        end
      end
      optcfg_pkg::S_STOP: begin
        if (i_ext_reset) begin
          long_rec = 1'b1;
          r_d.st   = optcfg_pkg::S_WAIT;
        end else if (i_wake) begin
          long_rec = !r_q.opt[optcfg_pkg::B_SHORT_STOP_RECOVERY];
          r_d.st   = optcfg_pkg::S_WAIT;
        end
        r_d.cnt = long_rec ? optcfg_pkg::STOP_LONG_CYC
                           : optcfg_pkg::STOP_SHORT_CYC;
      end
      optcfg_pkg::S_WAIT: begin
        if (i_osc_tick) begin
          if (r_q.cnt == optcfg_pkg::CNT_ONE) begin
            r_d.st  = optcfg_pkg::S_RUN;
            r_d.cnt = optcfg_pkg::CNT_ZERO;
          end else begin
            r_d.cnt = r_q.cnt - optcfg_pkg::CNT_ONE;
          end
        end
      end
      default: begin
        r_d.st = optcfg_pkg::S_RUN;
      end
    endcase
    // power-on stabilisation uses the long delay
    if (i_por) begin
      r_d.st  = optcfg_pkg::S_WAIT;
      r_d.cnt = optcfg_pkg::STOP_LONG_CYC;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      r_q.opt   <= optcfg_pkg::OPT_RESET;
      r_q.used  <= 1'b0;
      r_q.rdata <= 8'h00;
      r_q.st    <= optcfg_pkg::S_WAIT;
      r_q.cnt   <= optcfg_pkg::STOP_LONG_CYC;
    end else begin
      r_q <= r_d;
    end
  end

  assign o_rdata          = r_q.rdata;
  assign o_slow_crystal   = r_q.opt[optcfg_pkg::B_SLOW];
  assign o_mon_expect_low = r_q.opt[optcfg_pkg::B_SLOW];
  assign o_lvd_power      = r_q.opt[optcfg_pkg::B_LVPWR];
  assign o_lvd_stop_run   = r_q.opt[optcfg_pkg::B_LVPWR]
                          & r_q.opt[optcfg_pkg::B_LVSTP];
  assign o_lvd_reset_req  = i_lvd_trip
                          & r_q.opt[optcfg_pkg::B_LVRST]
                          & r_q.opt[optcfg_pkg::B_LVPWR];
  assign o_stop_legal     = r_q.opt[optcfg_pkg::B_STOP];
  assign o_stop_illegal   = i_stop_req
                          & !r_q.opt[optcfg_pkg::B_STOP]
                          & (r_q.st == optcfg_pkg::S_RUN);
  assign o_in_stop        = (r_q.st == optcfg_pkg::S_STOP);
  assign o_recovering     = (r_q.st == optcfg_pkg::S_WAIT);
  assign o_wd_rate_short  = r_q.opt[optcfg_pkg::B_WDRS];
  assign o_wd_timeout     = r_q.opt[optcfg_pkg::B_WDRS]
                          ? optcfg_pkg::WD_SHORT_CYC
                          : optcfg_pkg::WD_LONG_CYC;
  assign o_wd_enable      = !r_q.opt[optcfg_pkg::B_WDDIS]
                          & !(i_monitor_mode
                              & (i_hv_irq | i_hv_rst));

endmodule

// ==== sim/optcfg_sva.sv ====
// port assertions for the option latch block
`timescale 1ns/100ps
module optcfg_sva (
  input wire logic        i_clk_sys, i_rstn, i_rd, i_wr, i_stop_req,
  input wire logic        i_lvd_trip, i_monitor_mode, i_hv_irq, i_hv_rst,
  input wire logic [7:0]  o_rdata,
  input wire logic        o_lvd_power, o_lvd_stop_run, o_lvd_reset_req,
  input wire logic        o_slow_crystal, o_mon_expect_low, o_stop_legal,
  input wire logic        o_stop_illegal, o_in_stop, o_recovering,
  input wire logic        o_wd_enable, o_wd_rate_short,
  input wire logic [18:0] o_wd_timeout
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  a_lvd_stop_run: assert property (o_lvd_stop_run |-> o_lvd_power)
    else $error("stop run without power");
  a_lvd_reset_gate: assert property
    (o_lvd_reset_req |-> i_lvd_trip && o_lvd_power)
    else $error("reset request ungated");
  a_wd_monitor: assert property
    (i_monitor_mode && (i_hv_irq || i_hv_rst) |-> !o_wd_enable)
    else $error("watchdog on in monitor");
  a_wd_rate: assert property
    (o_wd_timeout == (o_wd_rate_short ? 19'h01FF0 : 19'h3FFF0))
    else $error("bad timeout");
  a_slow_monitor: assert property (o_mon_expect_low == o_slow_crystal)
    else $error("monitor range mismatch");
  a_stop_illegal: assert property
    (i_stop_req && !o_stop_legal && !o_in_stop && !o_recovering
     |-> o_stop_illegal)
    else $error("stop not illegal");
  a_read_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside slot");
  a_write_once: assert property (!$past(i_wr) |->
    $stable({o_slow_crystal, o_lvd_power, o_wd_rate_short, o_stop_legal}))
    else $error("options changed without write");
endmodule
bind optcfg_top optcfg_sva i_sva (.*);

// ==== sim/optcfg_top_tb.sv ====
// self-checking bench for the option latch block
`timescale 1ns/100ps
module optcfg_top_tb;
  logic i_clk_sys = 0, i_rstn = 0, i_wr = 0, i_rd = 0, i_osc_tick = 1;
  logic i_por = 0, i_stop_req = 0, i_wake = 0, i_ext_reset = 0;
  logic i_lvd_trip = 0, i_monitor_mode = 0, i_hv_irq = 0, i_hv_rst = 0;
  logic [15:0] i_addr = 0;
  logic [7:0]  i_wdata = 0, o_rdata, v;
  logic o_lvd_power, o_lvd_stop_run, o_lvd_reset_req, o_slow_crystal;
  logic o_mon_expect_low, o_stop_legal, o_stop_illegal, o_in_stop;
  logic o_recovering, o_wd_enable, o_wd_rate_short;
  logic [18:0] o_wd_timeout;
  int miscompares = 0, compares = 0, n;
  optcfg_top i_dut (.*);
  initial forever #4 i_clk_sys = ~i_clk_sys;
  task automatic chk(logic [18:0] s, logic [18:0] e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic complete_run;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one strobe cycle; a read is checked in the slot after its strobe
  task automatic acc(logic w, logic [15:0] a, logic [7:0] d, e);
    @(posedge i_clk_sys);
    i_wr <= w; i_rd <= !w; i_addr <= a; i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 0; i_rd <= 0;
    #1 if (!w) chk(o_rdata, e);
  endtask
  task automatic rec_len(int e);
    n = 0;
    while (o_recovering === 1'b1 && n < 5000) begin
      @(posedge i_clk_sys); #1 n++;
    end
    chk(n >= e - 2 && n <= e + 2, 1);
  endtask
  initial begin
    void'($urandom(32'h35C6BCBD));
    for (int k = 0; k < 4; k++) begin
      v = $urandom;
      v[1] = k[0];
      v[2] = k[1];
      i_rstn = 0; i_monitor_mode = 0; i_lvd_trip = 0;
      repeat (12) @(posedge i_clk_sys);
      i_rstn <= 1;
      #1 rec_len(4096);
      acc(0, 16'h001F, 0, 8'h30);
      acc(1, 16'h001F, v, 0);
      acc(0, 16'h001F, 0, v);
      acc(1, 16'h001F, ~v, 0);
      acc(0, 16'h001E, 0, 0);
      acc(0, 16'h001F, 0, v);
      chk({o_slow_crystal, o_mon_expect_low}, {2{v[7]}});
      chk({o_lvd_power, o_lvd_stop_run}, {v[4], v[4] & v[6]});
      i_lvd_trip <= 1;
      #8 chk(o_lvd_reset_req, v[5] & v[4]);
      chk(o_wd_timeout, v[3] ? 19'h01FF0 : 19'h3FFF0);
      chk(o_wd_enable, !v[0]);
      i_monitor_mode <= 1; i_hv_irq <= 1; i_hv_rst <= k[0];
      #8 chk(o_wd_enable, 0);
      i_hv_irq <= 0; i_hv_rst <= 0;
      #8 chk(o_wd_enable, !v[0]);
      i_stop_req <= 1;
      #8 chk(o_stop_illegal, !v[1]);
      i_stop_req <= 0;
      #8 chk(o_in_stop, v[1]);
      if (v[1]) begin
        i_wake <= 1;
        #8 i_wake <= 0;
        #1 rec_len(v[2] ? 32 : 4096);
        i_stop_req <= 1;
        #7 i_stop_req <= 0; i_ext_reset <= 1;
        #8 i_ext_reset <= 0;
        #1 rec_len(4096);
      end
      // a power-on event in mid-run restarts the long stabilisation wait
      i_por <= 1;
      #8 i_por <= 0;
      #1 rec_len(4096);
    end
    complete_run();
  end
  initial begin
    #800000 miscompares++;
    complete_run();
  end
endmodule
